// file: rtl/pcrb_cfg.svh
`ifndef PCRB_CFG_SVH
`define PCRB_CFG_SVH

// Register addresses
`define PCRB_A_IND      6'h00
`define PCRB_A_RTC      6'h01
`define PCRB_A_PC       6'h02
`define PCRB_A_STAT     6'h03
`define PCRB_A_RSEL     6'h04
`define PCRB_A_R5       6'h05
`define PCRB_A_R6       6'h06
`define PCRB_A_R7       6'h07
`define PCRB_A_PAGED_LO 6'h05
`define PCRB_A_PAGED_HI 6'h0e
`define PCRB_A_COMMON   6'h10
`define PCRB_A_BANKED   6'h20

// Status field positions
`define PCRB_ST_C       0
`define PCRB_ST_AC      1
`define PCRB_ST_Z       2
`define PCRB_ST_P       3
`define PCRB_ST_T       4
`define PCRB_ST_IOPG    5
`define PCRB_ST_RPG     6
`define PCRB_ST_RPG2    7

// Reset values
`define PCRB_STAT_RST   8'h18
`define PCRB_RSEL_RST   8'h00
`define PCRB_PS_RST     4'h0
`define PCRB_DADDR_RST  4'h0
`define PCRB_PC_RST     14'h0000

// Sizes
`define PCRB_PC_W       14
`define PCRB_JMP_W      10
`define PCRB_INT_VEC    14'h0008
`define PCRB_STK_DEPTH  16
`define PCRB_STK_PW     4
`define PCRB_DISP_WORDS 10
`define PCRB_DISP_LAST  4'h9
`define PCRB_COMMON_N   16
`define PCRB_BANK_N     32
`define PCRB_RAM_WORDS  144

// Real-time counter tick rate, Hz
`define PCRB_TICK_HZ    16384

`endif

// file: rtl/pcrb_pkg.sv
`default_nettype none
package pcrb_pkg;

   typedef enum logic [3:0] {
      PCRB_OP_HOLD,
      PCRB_OP_NEXT,
      PCRB_OP_JMP,
      PCRB_OP_CALL,
      PCRB_OP_RET,
      PCRB_OP_LRET,
      PCRB_OP_IRET,
      PCRB_OP_MOV_PC,
      PCRB_OP_ADD_PC,
      PCRB_OP_TABLE,
      PCRB_OP_INTR
   } pcrb_op_t;

   typedef enum logic [1:0] {
      PCRB_PG0,
      PCRB_PG1,
      PCRB_PG2
   } pcrb_register_page_bit_t;

endpackage
`default_nettype wire

// file: rtl/pcrb_stack.sv
`timescale 1ns/1ns
`default_nettype none
`include "pcrb_cfg.svh"

module pcrb_stack (
   input  wire logic                   clk,
   input  wire logic                   nrst,
   input  wire logic                   push,
   input  wire logic                   pop,
   input  wire logic [`PCRB_PC_W-1:0]  push_data,
   output logic      [`PCRB_PC_W-1:0]  top
);

   logic [`PCRB_PC_W-1:0]  mem [0:`PCRB_STK_DEPTH-1];
   logic [`PCRB_STK_PW-1:0] sp_ff;
   logic [`PCRB_STK_PW-1:0] top_idx;

   // Pointer wraps, so a seventeenth nesting overwrites the oldest entry
   assign top_idx = sp_ff - 4'h1;
   assign top     = mem[top_idx];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sp_ff <= '0;
      end else if (push) begin
         sp_ff <= sp_ff + 4'h1;
      end else if (pop) begin
         sp_ff <= top_idx;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[sp_ff] <= push_data;
      end
   end

endmodule
`default_nettype wire

// file: rtl/pcrb_core.sv
//
// How it works
// - Address zero has no storage; it accesses the register named by the select register.
// - Real-time counter counts slow ticks or instruction cycles; software reads and writes it.
// - Program counter is 14 bits wide, addressing 16k words of 13-bit code.
// - Jump loads the low ten counter bits from the operand.
// - Call pushes counter plus one, then loads the low ten bits from operand.
// - Return, return-with-literal and interrupt return pop the stack into the counter.
// - Return stack holds sixteen nested entries.
// - Move accumulator to counter loads low byte, clears bits eight and nine.
// - Add accumulator to counter adds offset, then clears bits eight and nine.
// - Table read adds accumulator offset, keeping bits eight and nine.
// - Jump, call, add and move take the top four bits from page bits.
// - Interrupt vectors to 0x08 page 0, saving accumulator, status, page; return restores all but status T and P.
// - Status bits 0..2 are carry, aux carry, zero; all software writable.
// - Power-down bit set by power on or watchdog clear, cleared by sleep; read-only.
// - Time-out bit set by sleep, watchdog clear, power up; cleared by timeout.
// - Time-out and power-down flags encode the wake or reset cause.
// - Status bit 5 selects I/O control page 0 or 1; resets to 0.
// - Status bit 7 selects register page 2, else bit 6 picks page 0/1.
// - Select register bits 0..5 give indirect target; bits 6..7 pick one of four banks.
// - Addresses 0x10..0x1F are common; 0x20..0x3F hold 32 bytes per bank.
// - Port 5 page 0 bits 0..3 select one of sixteen program pages.
// - Four-bit display address, reset 0, picks one of ten display bytes.
// - Display data register reads/writes addressed byte; odd segment high, even low.
//
`timescale 1ns/1ns
`default_nettype none
`include "pcrb_cfg.svh"

module pcrb_core
   import pcrb_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   nrst,
   input  wire pcrb_op_t               op,
   input  wire logic [`PCRB_JMP_W-1:0] operand,
   input  wire logic [7:0]             acc,
   input  wire logic [5:0]             reg_addr,
   input  wire logic                   reg_wr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   alu_flag_we,
   input  wire logic [2:0]             alu_flags,
   input  wire logic                   wdog_clr_cmd,
   input  wire logic                   sleep_cmd,
   input  wire logic                   wdt_timeout,
   input  wire logic                   ext_reset_wake,
   input  wire logic                   rtc_src_instr,
   input  wire logic                   tick_16k,
   input  wire logic                   instr_tick,
   input  wire logic                   tone_detect_in,
   output logic      [`PCRB_PC_W-1:0]  pc_ff,
   output logic      [7:0]             rd_data_ff,
   output logic      [7:0]             status_ff,
   output logic      [7:0]             port5_ff,
   output logic      [7:0]             port6_ff,
   output logic      [7:0]             port7_ff,
   output logic                        ram_bank_ff,
   output logic      [7:0]             acc_restore_ff,
   output logic                        acc_restore_vld_ff
);

   logic [7:0]              rtc_ff;
   logic [7:0]              rsel_ff;
   logic [3:0]              disp_addr_ff;
   logic [7:0]              saved_status_ff;
   logic [3:0]              saved_ps_ff;
   logic [7:0]              ram_mem  [0:`PCRB_RAM_WORDS-1];
   logic [7:0]              disp_mem [0:`PCRB_DISP_WORDS-1];

   logic [7:0]              nxt_rtc;
   logic [7:0]              nxt_status;
   logic [7:0]              nxt_port5;
   logic [`PCRB_PC_W-1:0]   nxt_pc;
   logic [7:0]              rd_mux;

   logic [5:0]              eff_addr;
   pcrb_register_page_bit_t             register_page_bit;
   logic                    paged;
   logic                    pg0;
   logic                    pg1;
   logic                    mem_hit;
   logic [7:0]              mem_idx;
   logic                    disp_ok;
   logic                    wr;
   logic                    wr_rtc;
   logic                    wr_stat;
   logic                    wr_rsel;
   logic                    wr_pc;
   logic                    wr_p5;
   logic                    wr_p6;
   logic                    wr_p7;
   logic                    wr_daddr;
   logic                    wr_ddata;
   logic                    wr_bank;
   logic                    rtc_inc;
   logic                    stk_push;
   logic                    stk_pop;
   logic [`PCRB_PC_W-1:0]   stk_top;
   logic [`PCRB_PC_W-1:0]   pc_plus1;
   logic [7:0]              pc_rel;
   logic [3:0]              ps;

   // Maps a common or banked address onto the flat RAM array
   function automatic logic [7:0] ram_index(input logic [5:0] a, input logic [1:0] bank);
      logic [7:0] base;
      base = 8'h00;
      if (a < `PCRB_A_BANKED) begin
         base = {2'b00, a} - {2'b00, `PCRB_A_COMMON};
      end else begin
         base = 8'(`PCRB_COMMON_N) + {1'b0, bank, 5'b00000} + {3'b000, a[4:0]};
      end
      return base;
   endfunction

   // Resolves an address range test used by both decode and read paths
   function automatic logic in_range(input logic [5:0] a, input logic [5:0] lo,
                                     input logic [5:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   assign eff_addr = (reg_addr == `PCRB_A_IND) ? rsel_ff[5:0] : reg_addr;

   assign register_page_bit = status_ff[`PCRB_ST_RPG2] ? PCRB_PG2 :
                  status_ff[`PCRB_ST_RPG]  ? PCRB_PG1 : PCRB_PG0;
   assign paged = in_range(eff_addr, `PCRB_A_PAGED_LO, `PCRB_A_PAGED_HI);
   assign pg0   = (register_page_bit == PCRB_PG0);
   assign pg1   = (register_page_bit == PCRB_PG1);

   assign mem_hit = in_range(eff_addr, `PCRB_A_COMMON, 6'h3f);
   assign mem_idx = ram_index(eff_addr, rsel_ff[7:6]);

   assign disp_ok = (disp_addr_ff <= `PCRB_DISP_LAST);

   // Address zero aimed at itself goes nowhere
   assign wr       = reg_wr && (eff_addr != `PCRB_A_IND);
   assign wr_rtc   = wr && (eff_addr == `PCRB_A_RTC);
   assign wr_stat  = wr && (eff_addr == `PCRB_A_STAT);
   assign wr_rsel  = wr && (eff_addr == `PCRB_A_RSEL);
   assign wr_pc    = wr && (eff_addr == `PCRB_A_PC);
   assign wr_p5    = wr && (eff_addr == `PCRB_A_R5) && pg0;
   assign wr_p6    = wr && (eff_addr == `PCRB_A_R6) && pg0;
   assign wr_p7    = wr && (eff_addr == `PCRB_A_R7) && pg0;
   assign wr_daddr = wr && (eff_addr == `PCRB_A_R5) && pg1;
   assign wr_ddata = wr && (eff_addr == `PCRB_A_R6) && pg1 && disp_ok;
   assign wr_bank  = wr && (eff_addr == `PCRB_A_R7) && pg1;

   assign rtc_inc = rtc_src_instr ? instr_tick : tick_16k;
   // A software write wins over a counting edge in the same cycle
   assign nxt_rtc = wr_rtc ? reg_wdata : (rtc_inc ? rtc_ff + 8'h01 : rtc_ff);

   assign ps = port5_ff[3:0];

   // Bit 4 of port 5 stays zero
   always_comb begin
      nxt_port5 = port5_ff;
      if (op == PCRB_OP_IRET) begin
         nxt_port5[3:0] = saved_ps_ff;
      end else if (wr_p5) begin
         nxt_port5 = {reg_wdata[7:5], 1'b0, reg_wdata[3:0]};
      end
   end

   // Status update; hardware flag sets win over their clears
   always_comb begin
      nxt_status = status_ff;
      if (op == PCRB_OP_IRET) begin
         nxt_status[2:0] = saved_status_ff[2:0];
         nxt_status[7:5] = saved_status_ff[7:5];
      end else if (wr_stat) begin
         nxt_status[2:0] = reg_wdata[2:0];
         nxt_status[`PCRB_ST_IOPG] = reg_wdata[`PCRB_ST_IOPG];
         nxt_status[`PCRB_ST_RPG]  = reg_wdata[`PCRB_ST_RPG];
         nxt_status[`PCRB_ST_RPG2] = reg_wdata[`PCRB_ST_RPG2];
      end else if (alu_flag_we) begin
         nxt_status[2:0] = alu_flags;
      end
      if (wdog_clr_cmd) begin
         nxt_status[`PCRB_ST_P] = 1'b1;
      end else if (sleep_cmd) begin
         nxt_status[`PCRB_ST_P] = 1'b0;
      end
      // Reset wake keeps P, sets T
      if (sleep_cmd || wdog_clr_cmd || ext_reset_wake) begin
         nxt_status[`PCRB_ST_T] = 1'b1;
      end else if (wdt_timeout) begin
         nxt_status[`PCRB_ST_T] = 1'b0;
      end
   end

   assign pc_plus1 = pc_ff + 14'h0001;
   assign pc_rel   = pc_ff[7:0] + acc;

   assign stk_push = (op == PCRB_OP_CALL) || (op == PCRB_OP_INTR);
   assign stk_pop  = (op == PCRB_OP_RET) || (op == PCRB_OP_LRET) || (op == PCRB_OP_IRET);

   pcrb_stack u_stack (
      .clk       (clk),
      .nrst      (nrst),
      .push      (stk_push),
      .pop       (stk_pop),
      .push_data ((op == PCRB_OP_CALL) ? pc_plus1 : pc_ff),
      .top       (stk_top)
   );

   always_comb begin
      nxt_pc = pc_ff;
      case (op)
         PCRB_OP_HOLD:   nxt_pc = pc_ff;
         PCRB_OP_NEXT:   nxt_pc = pc_plus1;
         PCRB_OP_JMP:    nxt_pc = {ps, operand};
         PCRB_OP_CALL:   nxt_pc = {ps, operand};
         PCRB_OP_RET,
         PCRB_OP_LRET,
         PCRB_OP_IRET:   nxt_pc = stk_top;
         PCRB_OP_MOV_PC: nxt_pc = {ps, 2'b00, acc};
         PCRB_OP_ADD_PC: nxt_pc = {ps, 2'b00, pc_rel};
         PCRB_OP_TABLE:  nxt_pc = {pc_ff[13:8], pc_rel};
         PCRB_OP_INTR:   nxt_pc = `PCRB_INT_VEC;
         default:        nxt_pc = pc_ff;
      endcase
      // A register write to the counter behaves as a move from the data
      if (wr_pc) begin
         nxt_pc = {ps, 2'b00, reg_wdata};
      end
   end

   // Read selection
   always_comb begin
      rd_mux = 8'h00;
      if (mem_hit) begin
         rd_mux = ram_mem[mem_idx];
      end else if (paged) begin
         // Page 2 and unmodelled slots read zero
         case (register_page_bit)
            PCRB_PG0: begin
               case (eff_addr)
                  `PCRB_A_R5: rd_mux = port5_ff;
                  `PCRB_A_R6: rd_mux = port6_ff;
                  `PCRB_A_R7: rd_mux = port7_ff;
                  default:    rd_mux = 8'h00;
               endcase
            end
            PCRB_PG1: begin
               case (eff_addr)
                  `PCRB_A_R5: rd_mux = {4'h0, disp_addr_ff};
                  `PCRB_A_R6: rd_mux = disp_ok ? disp_mem[disp_addr_ff] : 8'h00;
                  `PCRB_A_R7: rd_mux = {1'b0, tone_detect_in, 5'b00000, ram_bank_ff};
                  default:    rd_mux = 8'h00;
               endcase
            end
            default: rd_mux = 8'h00;
         endcase
      end else begin
         case (eff_addr)
            `PCRB_A_RTC:  rd_mux = rtc_ff;
            `PCRB_A_PC:   rd_mux = pc_ff[7:0];
            `PCRB_A_STAT: rd_mux = status_ff;
            `PCRB_A_RSEL: rd_mux = rsel_ff;
            default:      rd_mux = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pc_ff      <= `PCRB_PC_RST;
         rd_data_ff <= 8'h00;
         rtc_ff     <= 8'h00;
      end else begin
         pc_ff      <= nxt_pc;
         rd_data_ff <= rd_mux;
         rtc_ff     <= nxt_rtc;
      end
   end

   // Power-on value sets both T and P
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_ff <= `PCRB_STAT_RST;
         port5_ff  <= {4'h0, `PCRB_PS_RST};
      end else begin
         status_ff <= nxt_status;
         port5_ff  <= nxt_port5;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rsel_ff      <= `PCRB_RSEL_RST;
         port6_ff     <= 8'h00;
         port7_ff     <= 8'h00;
         disp_addr_ff <= `PCRB_DADDR_RST;
         ram_bank_ff  <= 1'b0;
      end else begin
         if (wr_rsel) rsel_ff <= reg_wdata;
         if (wr_p6) port6_ff <= reg_wdata;
         if (wr_p7) port7_ff <= reg_wdata;
         if (wr_daddr) disp_addr_ff <= reg_wdata[3:0];
         if (wr_bank) ram_bank_ff <= reg_wdata[0];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         saved_status_ff    <= 8'h00;
         saved_ps_ff        <= 4'h0;
         acc_restore_ff     <= 8'h00;
         acc_restore_vld_ff <= 1'b0;
      end else begin
         acc_restore_vld_ff <= (op == PCRB_OP_IRET);
         if (op == PCRB_OP_INTR) begin
            saved_status_ff <= status_ff;
            saved_ps_ff     <= ps;
            acc_restore_ff  <= acc;
         end
      end
   end

   // Storage arrays carry no reset; software initialises them
   always_ff @(posedge clk) begin
      if (wr && mem_hit) ram_mem[mem_idx] <= reg_wdata;
      if (wr_ddata) disp_mem[disp_addr_ff] <= reg_wdata;
   end

endmodule
`default_nettype wire

// file: testbench/pcrb_core_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "pcrb_cfg.svh"

module pcrb_core_chk
   import pcrb_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   nrst,
   input  wire pcrb_op_t               op,
   input  wire logic [`PCRB_JMP_W-1:0] operand,
   input  wire logic [7:0]             acc,
   input  wire logic [5:0]             reg_addr,
   input  wire logic                   reg_wr,
   input  wire logic                   wdog_clr_cmd,
   input  wire logic                   sleep_cmd,
   input  wire logic                   wdt_timeout,
   input  wire logic                   ext_reset_wake,
   input  wire logic [`PCRB_PC_W-1:0]  pc_ff,
   input  wire logic [7:0]             rd_data_ff,
   input  wire logic [7:0]             status_ff,
   input  wire logic [7:0]             port5_ff,
   input  wire logic                   acc_restore_vld_ff
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Counter writes override the op; those cycles and page-register writes are skipped
   wire logic       quiet = !(reg_wr && (reg_addr == `PCRB_A_PC || reg_addr == `PCRB_A_R5));
   wire logic [3:0] ps    = port5_ff[3:0];
   wire logic       calm  = !(wdog_clr_cmd || sleep_cmd || wdt_timeout || ext_reset_wake);

   sequence s_call;
      op == PCRB_OP_CALL && quiet;
   endsequence
   sequence s_ret;
      op == PCRB_OP_RET && quiet;
   endsequence

   jump_load_a: assert property (op == PCRB_OP_JMP && quiet |=>
      pc_ff == {$past(ps), $past(operand)}) else $error("jump target wrong");
   call_ret_a: assert property (s_call ##1 s_ret |=>
      pc_ff == $past(pc_ff, 2) + 14'h0001) else $error("call return pair wrong");
   mov_pc_a: assert property (op == PCRB_OP_MOV_PC && quiet |=>
      pc_ff == {$past(ps), 2'b00, $past(acc)}) else $error("move to counter wrong");
   add_pc_a: assert property (op == PCRB_OP_ADD_PC && quiet |=>
      pc_ff == {$past(ps), 2'b00, $past(pc_ff[7:0]) + $past(acc)}) else $error("add wrong");
   table_keep_a: assert property (op == PCRB_OP_TABLE && quiet |=>
      pc_ff == {$past(pc_ff[13:8]), $past(pc_ff[7:0]) + $past(acc)}) else $error("table wrong");
   intr_vec_a: assert property (op == PCRB_OP_INTR && quiet |=>
      pc_ff == `PCRB_INT_VEC) else $error("interrupt vector wrong");
   restore_vld_a: assert property (op == PCRB_OP_IRET |=> acc_restore_vld_ff)
      else $error("restore strobe missing");
   sleep_flags_a: assert property (sleep_cmd && !wdog_clr_cmd |=>
      status_ff[4:3] == 2'b10) else $error("sleep flags wrong");
   wclr_flags_a: assert property (wdog_clr_cmd |=> status_ff[4:3] == 2'b11)
      else $error("watchdog clear flags wrong");
   timeout_a: assert property (wdt_timeout && !sleep_cmd && !wdog_clr_cmd
      && !ext_reset_wake |=> status_ff[4:3] == {1'b0, $past(status_ff[3])})
      else $error("timeout flags wrong");
   flags_ro_a: assert property (reg_wr && reg_addr == `PCRB_A_STAT && calm |=>
      status_ff[4:3] == $past(status_ff[4:3])) else $error("flags written by software");
   undef_zero_a: assert property (reg_addr[5:3] == 3'b001 |=> rd_data_ff == 8'h00)
      else $error("unmapped read not zero");
endmodule

bind pcrb_core pcrb_core_chk u_chk (
   .clk(clk), .nrst(nrst), .op(op), .operand(operand), .acc(acc), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .wdog_clr_cmd(wdog_clr_cmd), .sleep_cmd(sleep_cmd), .wdt_timeout(wdt_timeout),
   .ext_reset_wake(ext_reset_wake), .pc_ff(pc_ff), .rd_data_ff(rd_data_ff),
   .status_ff(status_ff), .port5_ff(port5_ff), .acc_restore_vld_ff(acc_restore_vld_ff)
);
`default_nettype wire

// file: testbench/pcrb_core_tb.sv
`timescale 1ns/1ns
`default_nettype none

module pcrb_core_tb
   import pcrb_pkg::*;
;
   logic        clk, nrst, wr, alu_we, src, t16, itk, tone;
   pcrb_op_t    op;
   logic [9:0]  operand;
   logic [7:0]  acc, wdata, rsd, st, p5, p6, p7, ar;
   logic [5:0]  addr;
   logic [2:0]  alu_fl;
   logic [3:0]  cmd;
   logic [13:0] pc, e;
   logic [13:0] stk [16];
   logic        rb, arv;
   int          fails, checks;

   pcrb_core u_dut (
      .clk(clk), .nrst(nrst), .op(op), .operand(operand), .acc(acc), .reg_addr(addr),
      .reg_wr(wr), .reg_wdata(wdata), .alu_flag_we(alu_we), .alu_flags(alu_fl),
      .wdog_clr_cmd(cmd[0]), .sleep_cmd(cmd[1]), .wdt_timeout(cmd[2]), .ext_reset_wake(cmd[3]),
      .rtc_src_instr(src), .tick_16k(t16), .instr_tick(itk), .tone_detect_in(tone),
      .pc_ff(pc), .rd_data_ff(rsd), .status_ff(st), .port5_ff(p5), .port6_ff(p6),
      .port7_ff(p7), .ram_bank_ff(rb), .acc_restore_ff(ar), .acc_restore_vld_ff(arv)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic wreg(input logic [5:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a; wdata = d; wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask

   task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
      @(negedge clk);
      addr = a;
      @(negedge clk);
      chk("read", rsd, exp);
   endtask

   // Leaves op applied so that ops can follow back to back
   task automatic run(input pcrb_op_t o, input logic [9:0] n, input logic [7:0] a,
                      input logic [13:0] x);
      @(negedge clk);
      op = o; operand = n; acc = a;
      @(posedge clk);
      #1 chk("pc", pc, x);
   endtask

   task automatic pulse(input logic [3:0] c, input logic [1:0] x);
      @(negedge clk);
      cmd = c;
      @(negedge clk);
      cmd = 4'h0;
      chk("t_p", st[4:3], x);
   endtask

   task automatic tick(input logic s, input logic [1:0] t);
      @(negedge clk);
      src = s; {itk, t16} = t;
      @(negedge clk);
      {itk, t16} = 2'b00;
   endtask

   task automatic t_reset;
      rdc(6'h03, 8'h18);
      chk("pc0", pc, 14'h0000);
      rdc(6'h05, 8'h00);
   endtask

   task automatic t_bank;
      wreg(6'h04, 8'h25);
      wreg(6'h00, 8'haa);
      rdc(6'h25, 8'haa);
      wreg(6'h04, 8'h65);
      wreg(6'h00, 8'h55);
      rdc(6'h25, 8'h55);
      wreg(6'h10, 8'h3c);
      wreg(6'h04, 8'he5);
      rdc(6'h10, 8'h3c);
      wreg(6'h00, 8'h77);
      rdc(6'h25, 8'h77);
      wreg(6'h04, 8'h25);
      rdc(6'h00, 8'haa);
   endtask

   task automatic t_pc;
      wreg(6'h05, 8'hf2);
      rdc(6'h05, 8'he2);
      run(PCRB_OP_JMP, 10'h3f0, 8'h00, 14'h0bf0);
      run(PCRB_OP_TABLE, 10'h000, 8'h05, 14'h0bf5);
      run(PCRB_OP_ADD_PC, 10'h000, 8'h05, 14'h08fa);
      run(PCRB_OP_MOV_PC, 10'h000, 8'h33, 14'h0833);
      run(PCRB_OP_NEXT, 10'h000, 8'h00, 14'h0834);
      run(PCRB_OP_JMP, 10'h000, 8'h00, 14'h0800);
      e = 14'h0800;
      for (int i = 0; i < 16; i++) begin
         stk[i] = e + 14'h0001;
         e = {4'h2, 10'(i * 8 + 3)};
         run(PCRB_OP_CALL, 10'(i * 8 + 3), 8'h00, e);
      end
      for (int i = 15; i >= 0; i--) begin
         run(PCRB_OP_RET, 10'h000, 8'h00, stk[i]);
      end
      @(negedge clk);
      op = PCRB_OP_HOLD;
      wreg(6'h02, 8'h44);
      chk("pc_wr", pc, 14'h0844);
   endtask

   task automatic t_intr;
      wreg(6'h03, 8'h05);
      run(PCRB_OP_JMP, 10'h155, 8'h00, 14'h0955);
      run(PCRB_OP_INTR, 10'h000, 8'h9a, 14'h0008);
      @(negedge clk);
      op = PCRB_OP_HOLD;
      wreg(6'h03, 8'h02);
      wreg(6'h05, 8'h00);
      run(PCRB_OP_IRET, 10'h000, 8'h00, 14'h0955);
      chk("vld", arv, 1'b1);
      @(negedge clk);
      op = PCRB_OP_HOLD;
      chk("st", st, 8'h1d);
      chk("ps", p5, 8'h02);
      chk("acc", ar, 8'h9a);
   endtask

   task automatic t_flags;
      pulse(4'h2, 2'b10);
      pulse(4'h4, 2'b00);
      pulse(4'h8, 2'b10);
      pulse(4'h1, 2'b11);
      pulse(4'h4, 2'b01);
      pulse(4'h3, 2'b11);
      @(negedge clk);
      alu_we = 1'b1; alu_fl = 3'b110;
      @(negedge clk);
      alu_we = 1'b0;
      chk("alu", st[2:0], 3'b110);
   endtask

   task automatic t_page;
      wreg(6'h03, 8'h40);
      rdc(6'h05, 8'h00);
      wreg(6'h05, 8'hf3);
      wreg(6'h06, 8'ha5);
      wreg(6'h05, 8'h09);
      wreg(6'h06, 8'h3c);
      rdc(6'h06, 8'h3c);
      wreg(6'h05, 8'hf3);
      rdc(6'h05, 8'h03);
      rdc(6'h06, 8'ha5);
      wreg(6'h05, 8'h0c);
      wreg(6'h06, 8'h77);
      rdc(6'h06, 8'h00);
      chk("p6", p6, 8'h00);
      tone = 1'b1;
      wreg(6'h07, 8'hff);
      rdc(6'h07, 8'h41);
      chk("bank", rb, 1'b1);
      rdc(6'h0b, 8'h00);
      wreg(6'h03, 8'h80);
      wreg(6'h05, 8'h07);
      rdc(6'h05, 8'h00);
      wreg(6'h03, 8'h20);
      rdc(6'h05, 8'h02);
      wreg(6'h06, 8'h5a);
      wreg(6'h07, 8'hc3);
      chk("p6", p6, 8'h5a);
      chk("p7", p7, 8'hc3);
      chk("bank", rb, 1'b1);
   endtask

   task automatic t_rtc;
      wreg(6'h01, 8'hfe);
      tick(1'b1, 2'b10);
      tick(1'b1, 2'b10);
      rdc(6'h01, 8'h00);
      tick(1'b0, 2'b10);
      tick(1'b0, 2'b01);
      rdc(6'h01, 8'h01);
   endtask

   initial begin
      nrst = 1'b0; wr = 1'b0; alu_we = 1'b0; src = 1'b0; t16 = 1'b0; itk = 1'b0;
      tone = 1'b0; op = PCRB_OP_HOLD; operand = 10'h000; acc = 8'h00; wdata = 8'h00;
      addr = 6'h00; alu_fl = 3'b000; cmd = 4'h0; fails = 0; checks = 0;
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      t_reset();
      t_bank();
      t_pc();
      t_intr();
      t_flags();
      t_page();
      t_rtc();
      end_of_test();
   end

   // Cuts a hang short
   initial begin
      #200000;
      fails++;
      end_of_test();
   end
endmodule
`default_nettype wire
